// >>> inc/syn_consts.svh
`ifndef SYN_CONSTS_SVH
`define SYN_CONSTS_SVH
// register offsets
`define SYN_ADDR_UPDATE    16'h0005
`define SYN_ADDR_NDIV      16'h0020
`define SYN_ADDR_RSVD      16'h0021
`define SYN_ADDR_PLL       16'h0022
`define SYN_ADDR_DIV_LO    16'h0104
`define SYN_ADDR_DIV_HI    16'h0105
`define SYN_ADDR_DIV_CTL   16'h0106
`define SYN_ADDR_TUNING_WORD_BYTE0      16'h01a6
`define SYN_FTW_NBYTES     16'h0006
// field positions
`define SYN_BIT_UPD        0
`define SYN_BIT_AUTO       7
`define SYN_BIT_DBL        3
`define SYN_BIT_BAND       2
`define SYN_BIT_INV        7
`define SYN_BIT_PRE        0
// reset values
`define SYN_NDIV_RST       5'h00
`define SYN_PLL_RST        8'h00
`define SYN_DIV_RST        16'h0000
`define SYN_DCTL_RST       2'h0
`define SYN_FB_RATIO_RST   7'h04
// offset of two ahead of the fixed doubling, so four after it; pump currents in uA
`define SYN_FB_OFFSET      7'h04
`define SYN_CP_UA_00       9'h0fa
`define SYN_CP_UA_01       9'h177
`define SYN_CP_UA_OFF      9'h000
`define SYN_CP_UA_11       9'h07d
`define SYN_CP_CODE_OFF    2'h2
// oscillator band split in MHz, between 810 and 900
`define SYN_BAND_SPLIT_MHZ 16'h0357
// cycles after reset release before straps are taken
`define SYN_BOOT_CYCLES    2'h2
`endif

// >>> inc/syn_pkg.sv
package syn_pkg;
  typedef enum logic [1:0] {
    SYN_IDLE = 2'b01,
    SYN_CALC = 2'b10
  } syn_band_st_t;
  typedef logic [47:0] syn_ftw_t;
  typedef logic [7:0]  syn_byte_t;
endpackage

// >>> inc/syn_cfg_if.sv
interface syn_cfg_if;
  import syn_pkg::*;
  syn_ftw_t    frequency_tuning_word;
  logic [15:0] div_val;
  logic        pre_en;
  logic        inv_edge;
  modport ctl (output frequency_tuning_word, output div_val, output pre_en, output inv_edge);
  modport acc (input frequency_tuning_word);
  modport div (input div_val, input pre_en, input inv_edge);
endinterface

// >>> src/syn_phase_acc.sv
module syn_phase_acc
  import syn_pkg::*;
#(
  parameter int unsigned PH_W = 14
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // active tuning word
  syn_cfg_if.acc           cfg,
  // phase to sine lookup
  output logic [PH_W-1:0]  phase_out
);
  syn_ftw_t acc_ff;
  syn_ftw_t nxt_acc;

  // never cleared on a new word, so frequency hops stay phase continuous
  always_comb begin
    nxt_acc = acc_ff + cfg.frequency_tuning_word; // [R13] [R14] [R18]
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_ff <= 48'h0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  assign phase_out = acc_ff[47 -: PH_W];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  AST_ACC_STEP: assert property ( // [R18] [R13]
    ##1 acc_ff == $past(acc_ff) + $past(cfg.frequency_tuning_word))
    else $error("accumulator did not advance by tuning word");
  AST_ACC_NO_JUMP: assert property ( // [R14]
    $changed(cfg.frequency_tuning_word) |-> acc_ff == $past(acc_ff) + $past(cfg.frequency_tuning_word))
    else $error("phase jumped on tuning word change");
endmodule // syn_phase_acc

// >>> src/syn_out_div.sv
module syn_out_div
  import syn_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // active divider settings
  syn_cfg_if.div    cfg,
  // synchronised divider reference level
  input  wire logic lvl_in,
  // divided output pulse
  output logic      div_out
);
  logic        prev_ff;
  logic        pre_ff;
  logic [15:0] cnt_ff;
  logic        out_ff;
  logic        nxt_pre;
  logic [15:0] nxt_cnt;
  logic        nxt_out;
  logic        edge_hit;
  logic        tick;

  always_comb begin
    edge_hit = cfg.inv_edge ? (prev_ff & ~lvl_in) : (~prev_ff & lvl_in); // [R11]
    tick     = edge_hit & (~cfg.pre_en | pre_ff); // [R09]
    nxt_pre  = edge_hit ? ~pre_ff : pre_ff;
    nxt_cnt  = cnt_ff;
    nxt_out  = 1'b0;
    if (tick) begin
      // terminal at the stored value, so the ratio is value plus one
      // at or past the value, so a lowered value never runs through a full wrap
      if (cnt_ff >= cfg.div_val) begin // [R07]
        nxt_cnt = 16'h0000;
        nxt_out = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_ff <= 1'b0;
      pre_ff  <= 1'b0;
      cnt_ff  <= 16'h0000;
      out_ff  <= 1'b0;
    end else begin
      prev_ff <= lvl_in;
      pre_ff  <= nxt_pre;
      cnt_ff  <= nxt_cnt;
      out_ff  <= nxt_out;
    end
  end

  assign div_out = out_ff;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  AST_DIV_TERMINAL: assert property ( // [R07]
    tick && cnt_ff >= cfg.div_val |=> div_out && cnt_ff == 16'h0000)
    else $error("divider missed terminal count");
  AST_PRE_SKIP: assert property ( // [R09]
    cfg.pre_en && edge_hit && !pre_ff |=> $stable(cnt_ff) && !div_out)
    else $error("prescaler passed a skipped edge");
  AST_INV_EDGE: assert property ( // [R11]
    cfg.inv_edge && !prev_ff && lvl_in |-> !edge_hit)
    else $error("inverted divider counted a rising edge");
endmodule // syn_out_div

// >>> src/syn_clk_cfg.sv
`include "syn_consts.svh"
// Overview of operation
// [R01] feedback ratio is twice the sum of the 5-bit divider field and two
// [R02] auto range bit makes the device choose the oscillator band itself
// [R03] band bit zero selects 700-810 MHz, one selects 900-1000 MHz
// [R04] software should use auto range for 810 to 900 MHz
// [R05] reference doubling bit inserts a doubler ahead of the PLL
// [R06] charge pump code 00=250uA, 01=375uA, 10=off, 11=125uA
// [R07] output divide ratio is the 16-bit value plus one
// [R08] low divider register holds bits 7:0, next holds 15:8
// [R09] divider control bit 0 adds a divide-by-two prescaler
// [R10] software must enable prescaler above 65536 or above 400 MHz input
// [R11] falling edge bit inverts the divider reference clock
// [R12] first tuning word register holds tuning word bits 7:0
// [R13] tuning word sets output to system clock frequency ratio
// [R14] new tuning word changes frequency at once without phase jump
// [R15] tuning word power-up value comes from the start-up straps
// [R16] tuning word is 48 bits in six registers, top holds 47:40
// [R17] writing the self-clearing update bit acts like the update pin
// [R18] 48-bit accumulator adds the active word each cycle, top bits out
module syn_clk_cfg
  import syn_pkg::*;
#(
  parameter int unsigned REF_MHZ = 50,
  parameter int unsigned PH_W    = 14
) (
  // clock and reset
  input  wire logic            ref_clk_in,
  input  wire logic            rst_in,
  // register access from the serial port logic
  input  wire logic [15:0]     reg_addr_in,
  input  wire logic            reg_wr_in,
  input  wire logic            reg_rd_in,
  input  wire logic [7:0]      reg_wdata_in,
  output logic      [7:0]      reg_rdata_out,
  output logic                 reg_rvalid_out,
  // device pins
  input  wire logic            io_update_pin_in,
  input  wire logic            feedback_input_pin_in,
  input  wire logic [3:0]      startup_straps_in,
  // pll settings
  output logic      [6:0]      fb_ratio_out,
  output logic                 ref_dbl_out,
  output logic                 osc_band_out,
  output logic                 cp_on_out,
  output logic      [8:0]      cp_ua_out,
  // synthesis outputs
  output logic      [PH_W-1:0] phase_out,
  output logic                 cmos_div_out
);
  // pin synchronisers: {update, feedback, straps}
  logic [5:0]   sync1_ff;
  logic [5:0]   sync2_ff;
  logic         upd_prev_ff;
  logic [1:0]   boot_cnt_ff;
  logic         boot_done_ff;
  logic [1:0]   nxt_boot_cnt;
  logic         nxt_boot_done;
  logic         boot_load;
  logic         upd_pulse;

  // buffered and active register state
  logic [4:0]   ndiv_buf_ff;
  logic [4:0]   ndiv_act_ff;
  syn_byte_t    pll_buf_ff;
  syn_byte_t    pll_act_ff;
  logic [15:0]  div_buf_ff;
  logic [15:0]  div_act_ff;
  logic [1:0]   dctl_buf_ff;
  logic [1:0]   dctl_act_ff;
  syn_ftw_t     ftw_buf_ff;
  syn_ftw_t     ftw_act_ff;
  logic [4:0]   nxt_ndiv_buf;
  logic [4:0]   nxt_ndiv_act;
  syn_byte_t    nxt_pll_buf;
  syn_byte_t    nxt_pll_act;
  logic [15:0]  nxt_div_buf;
  logic [15:0]  nxt_div_act;
  logic [1:0]   nxt_dctl_buf;
  logic [1:0]   nxt_dctl_act;
  syn_ftw_t     nxt_ftw_buf;
  syn_ftw_t     nxt_ftw_act;

  // band selection state
  syn_band_st_t st_ff;
  syn_band_st_t nxt_st;
  logic [15:0]  vco_ff;
  logic [15:0]  nxt_vco;
  logic         band_auto_ff;
  logic         nxt_band_auto;
  logic         eff_band;

  // registered outputs
  logic [7:0]   rdata_ff;
  logic         rvalid_ff;
  logic [6:0]   fb_ratio_ff;
  logic         ref_dbl_ff;
  logic         osc_band_ff;
  logic         cp_on_ff;
  logic [8:0]   cp_ua_ff;
  logic [7:0]   nxt_rdata;
  logic [6:0]   nxt_fb_ratio;
  logic [8:0]   nxt_cp_ua;

  syn_cfg_if cfg ();

  function automatic logic is_ftw(input logic [15:0] a);
    return (a >= `SYN_ADDR_TUNING_WORD_BYTE0) && (a < `SYN_ADDR_TUNING_WORD_BYTE0 + `SYN_FTW_NBYTES);
  endfunction

  function automatic logic [2:0] ftw_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - `SYN_ADDR_TUNING_WORD_BYTE0;
    return d[2:0];
  endfunction

  function automatic logic [8:0] cp_ua(input logic [1:0] code);
    case (code)
      2'h0:    return `SYN_CP_UA_00;
      2'h1:    return `SYN_CP_UA_01;
      2'h2:    return `SYN_CP_UA_OFF;
      default: return `SYN_CP_UA_11;
    endcase
  endfunction

  // arbitrary strap to tuning word mapping
  function automatic syn_ftw_t strap_ftw(input logic [3:0] s);
    return {s, 44'h0};
  endfunction

  // synchronisers and boot sequencing
  always_comb begin
    boot_load     = !boot_done_ff && (boot_cnt_ff == `SYN_BOOT_CYCLES);
    nxt_boot_cnt  = boot_done_ff ? boot_cnt_ff : boot_cnt_ff + 2'h1;
    nxt_boot_done = boot_done_ff | boot_load;
    upd_pulse     = (sync2_ff[5] & ~upd_prev_ff)
                  | (reg_wr_in && reg_addr_in == `SYN_ADDR_UPDATE
                     && reg_wdata_in[`SYN_BIT_UPD]); // [R17]
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_ff     <= 6'h00;
      sync2_ff     <= 6'h00;
      upd_prev_ff  <= 1'b0;
      boot_cnt_ff  <= 2'h0;
      boot_done_ff <= 1'b0;
    end else begin
      sync1_ff     <= {io_update_pin_in, feedback_input_pin_in, startup_straps_in};
      sync2_ff     <= sync1_ff;
      upd_prev_ff  <= sync2_ff[5];
      boot_cnt_ff  <= nxt_boot_cnt;
      boot_done_ff <= nxt_boot_done;
    end
  end

  // register writes into buffers, transfer to active on update
  always_comb begin
    nxt_ndiv_buf = ndiv_buf_ff;
    nxt_pll_buf  = pll_buf_ff;
    nxt_div_buf  = div_buf_ff;
    nxt_dctl_buf = dctl_buf_ff;
    nxt_ftw_buf  = ftw_buf_ff;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `SYN_ADDR_NDIV:    nxt_ndiv_buf = reg_wdata_in[4:0];
        `SYN_ADDR_PLL:     nxt_pll_buf = reg_wdata_in & 8'h8f;
        `SYN_ADDR_DIV_LO:  nxt_div_buf[7:0] = reg_wdata_in; // [R08]
        `SYN_ADDR_DIV_HI:  nxt_div_buf[15:8] = reg_wdata_in; // [R08]
        `SYN_ADDR_DIV_CTL: nxt_dctl_buf = {reg_wdata_in[`SYN_BIT_INV],
                                           reg_wdata_in[`SYN_BIT_PRE]};
        default:           nxt_ndiv_buf = ndiv_buf_ff;
      endcase
      if (is_ftw(reg_addr_in)) begin
        // byte n holds bits 8n+7:8n, byte 0 is least significant
        nxt_ftw_buf[ftw_idx(reg_addr_in)*8 +: 8] = reg_wdata_in; // [R12] [R16]
      end
    end
    nxt_ndiv_act = ndiv_act_ff;
    nxt_pll_act  = pll_act_ff;
    nxt_div_act  = div_act_ff;
    nxt_dctl_act = dctl_act_ff;
    nxt_ftw_act  = ftw_act_ff;
    // a write in the update cycle lands in the buffer, not the active copy
    if (upd_pulse) begin // [R17]
      nxt_ndiv_act = ndiv_buf_ff;
      nxt_pll_act  = pll_buf_ff;
      nxt_div_act  = div_buf_ff;
      nxt_dctl_act = dctl_buf_ff;
      nxt_ftw_act  = ftw_buf_ff;
    end
    if (boot_load) begin
      nxt_ftw_buf = strap_ftw(sync2_ff[3:0]); // [R15]
      nxt_ftw_act = strap_ftw(sync2_ff[3:0]); // [R15]
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ndiv_buf_ff <= `SYN_NDIV_RST;
      ndiv_act_ff <= `SYN_NDIV_RST;
      pll_buf_ff  <= `SYN_PLL_RST;
      pll_act_ff  <= `SYN_PLL_RST;
      div_buf_ff  <= `SYN_DIV_RST;
      div_act_ff  <= `SYN_DIV_RST;
      dctl_buf_ff <= `SYN_DCTL_RST;
      dctl_act_ff <= `SYN_DCTL_RST;
      ftw_buf_ff  <= 48'h0;
      ftw_act_ff  <= 48'h0;
    end else begin
      ndiv_buf_ff <= nxt_ndiv_buf;
      ndiv_act_ff <= nxt_ndiv_act;
      pll_buf_ff  <= nxt_pll_buf;
      pll_act_ff  <= nxt_pll_act;
      div_buf_ff  <= nxt_div_buf;
      div_act_ff  <= nxt_div_act;
      dctl_buf_ff <= nxt_dctl_buf;
      dctl_act_ff <= nxt_dctl_act;
      ftw_buf_ff  <= nxt_ftw_buf;
      ftw_act_ff  <= nxt_ftw_act;
    end
  end

  // automatic band: estimate oscillator frequency from the new settings
  always_comb begin
    nxt_st        = st_ff;
    nxt_vco       = vco_ff;
    nxt_band_auto = band_auto_ff;
    case (st_ff)
      SYN_IDLE: begin
        if (upd_pulse && pll_buf_ff[`SYN_BIT_AUTO]) begin
          nxt_vco = 16'(REF_MHZ * (pll_buf_ff[`SYN_BIT_DBL] ? 32'h2 : 32'h1)
                    * ({26'h0, ndiv_buf_ff, 1'b0} + {25'h0, `SYN_FB_OFFSET}));
          nxt_st  = SYN_CALC;
        end
      end
      SYN_CALC: begin
        nxt_band_auto = (vco_ff >= `SYN_BAND_SPLIT_MHZ); // [R02]
        nxt_st        = SYN_IDLE;
      end
      default: nxt_st = SYN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff        <= SYN_IDLE;
      vco_ff       <= 16'h0000;
      band_auto_ff <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      vco_ff       <= nxt_vco;
      band_auto_ff <= nxt_band_auto;
    end
  end

  // readback shows buffered values, except the band bit under auto range
  always_comb begin
    eff_band = pll_act_ff[`SYN_BIT_AUTO] ? band_auto_ff
                                         : pll_act_ff[`SYN_BIT_BAND]; // [R02] [R03]
    nxt_fb_ratio = {1'b0, ndiv_act_ff, 1'b0} + `SYN_FB_OFFSET; // [R01]
    nxt_cp_ua    = cp_ua(pll_act_ff[1:0]); // [R06]
    nxt_rdata    = rdata_ff;
    if (reg_rd_in) begin
      nxt_rdata = 8'h00;
      if (is_ftw(reg_addr_in)) begin
        nxt_rdata = ftw_buf_ff[ftw_idx(reg_addr_in)*8 +: 8];
      end
      case (reg_addr_in)
        `SYN_ADDR_NDIV:    nxt_rdata = {3'h0, ndiv_buf_ff};
        `SYN_ADDR_PLL:     nxt_rdata = pll_act_ff[`SYN_BIT_AUTO]
                                       ? {pll_buf_ff[7:3], band_auto_ff, pll_buf_ff[1:0]}
                                       : pll_buf_ff;
        `SYN_ADDR_DIV_LO:  nxt_rdata = div_buf_ff[7:0];
        `SYN_ADDR_DIV_HI:  nxt_rdata = div_buf_ff[15:8];
        `SYN_ADDR_DIV_CTL: nxt_rdata = {dctl_buf_ff[1], 6'h00, dctl_buf_ff[0]};
        default:           nxt_rdata = nxt_rdata;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff    <= 8'h00;
      rvalid_ff   <= 1'b0;
      fb_ratio_ff <= `SYN_FB_RATIO_RST;
      ref_dbl_ff  <= 1'b0;
      osc_band_ff <= 1'b0;
      cp_on_ff    <= 1'b0;
      cp_ua_ff    <= 9'h000;
    end else begin
      rdata_ff    <= nxt_rdata;
      rvalid_ff   <= reg_rd_in;
      fb_ratio_ff <= nxt_fb_ratio;
      ref_dbl_ff  <= pll_act_ff[`SYN_BIT_DBL]; // [R05]
      osc_band_ff <= eff_band;
      cp_on_ff    <= (pll_act_ff[1:0] != `SYN_CP_CODE_OFF); // [R06]
      cp_ua_ff    <= nxt_cp_ua;
    end
  end

  assign reg_rdata_out  = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;
  assign fb_ratio_out   = fb_ratio_ff;
  assign ref_dbl_out    = ref_dbl_ff;
  assign osc_band_out   = osc_band_ff;
  assign cp_on_out      = cp_on_ff;
  assign cp_ua_out      = cp_ua_ff;

  assign cfg.frequency_tuning_word      = ftw_act_ff;
  assign cfg.div_val  = div_act_ff;
  assign cfg.pre_en   = dctl_act_ff[0];
  assign cfg.inv_edge = dctl_act_ff[1];

  syn_phase_acc #(
    .PH_W       (PH_W)
  ) u_acc (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .cfg        (cfg.acc),
    .phase_out  (phase_out)
  );

  syn_out_div u_div (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .cfg        (cfg.div),
    .lvl_in     (sync2_ff[4]),
    .div_out    (cmos_div_out)
  );

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_auto_req;
    st_ff == SYN_IDLE && upd_pulse && pll_buf_ff[`SYN_BIT_AUTO];
  endsequence
  sequence s_auto_done;
    st_ff == SYN_CALC ##1 band_auto_ff == $past(vco_ff >= `SYN_BAND_SPLIT_MHZ);
  endsequence

  AST_FB_RATIO: assert property ( // [R01]
    ##1 fb_ratio_out == {1'b0, $past(ndiv_act_ff), 1'b0} + 7'h04)
    else $error("feedback ratio not twice field plus two");
  AST_AUTO_BAND: assert property (s_auto_req |=> s_auto_done) // [R02]
    else $error("automatic band not resolved");
  AST_MAN_BAND: assert property ( // [R03]
    !pll_act_ff[`SYN_BIT_AUTO] |=> osc_band_out == $past(pll_act_ff[`SYN_BIT_BAND]))
    else $error("manual band not followed");
  AST_DOUBLER: assert property ( // [R05]
    $changed(pll_act_ff[`SYN_BIT_DBL]) |=> ref_dbl_out == $past(pll_act_ff[`SYN_BIT_DBL]))
    else $error("doubler select not followed");
  AST_CP_OFF: assert property ( // [R06]
    pll_act_ff[1:0] == 2'h2 |=> !cp_on_out && cp_ua_out == 9'h000)
    else $error("charge pump not off");
  AST_CP_LOW: assert property ( // [R06]
    pll_act_ff[1:0] == 2'h3 |=> cp_on_out && cp_ua_out == 9'h07d)
    else $error("charge pump current not 125 uA");
  AST_DIV_HI: assert property ( // [R08]
    reg_wr_in && reg_addr_in == 16'h0105 |=> div_buf_ff[15:8] == $past(reg_wdata_in))
    else $error("divider high byte misplaced");
  AST_FTW_LSB: assert property ( // [R12]
    reg_wr_in && reg_addr_in == 16'h01a6 && boot_done_ff
    |=> ftw_buf_ff[7:0] == $past(reg_wdata_in))
    else $error("tuning word low byte misplaced");
  AST_FTW_MSB: assert property ( // [R16]
    reg_wr_in && reg_addr_in == 16'h01ab && boot_done_ff
    |=> ftw_buf_ff[47:40] == $past(reg_wdata_in))
    else $error("tuning word top byte misplaced");
  AST_STRAP: assert property ( // [R15]
    $rose(boot_done_ff) |-> ftw_act_ff == {$past(sync2_ff[3:0]), 44'h0})
    else $error("tuning word default not from straps");
  AST_UPD_SOFT: assert property ( // [R17]
    reg_wr_in && reg_addr_in == 16'h0005 && reg_wdata_in[0] && boot_done_ff
    |=> ftw_act_ff == $past(ftw_buf_ff) && div_act_ff == $past(div_buf_ff))
    else $error("update bit did not transfer buffers");
  AST_UPD_HOLD: assert property ( // [R17]
    boot_done_ff && !upd_pulse |=> $stable(ftw_act_ff) && $stable(pll_act_ff))
    else $error("active registers changed without update");
endmodule // syn_clk_cfg

// >>> tb/syn_host_model.sv
`include "syn_consts.svh"
module syn_host_model (
  // clock
  input  wire logic        clk_in,
  // register bus towards the device
  output logic      [15:0] addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [7:0]  wdata_out,
  input  wire logic [7:0]  rdata_in,
  input  wire logic        rvalid_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_out  = 16'hffff;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 8'h00;
  end
  // released lines show inverted leftovers so stale values never pass
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
    addr_out  = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output bit ok);
    int n;
    @(negedge clk_in);
    addr_out = a;
    rd_out   = 1'b1;
    @(negedge clk_in);
    rd_out   = 1'b0;
    addr_out = ~a;
    n = 0;
    while (rvalid_in !== 1'b1 && n < 8) begin
      @(negedge clk_in);
      n++;
    end
    ok = (n < 8);
    d  = rdata_in;
  endtask
  task automatic update();
    wr(`SYN_ADDR_UPDATE, 8'h01);
  endtask
  // 810..900 MHz is only ever reached through auto band select
  task automatic pll(input logic [4:0] n, input logic [7:0] ctl);
    wr(`SYN_ADDR_NDIV, {3'h0, n});
    wr(`SYN_ADDR_PLL, ctl);
    update();
  endtask
  task automatic set_divider(input int ratio);
    logic [15:0] v;
    if (ratio > 65536) begin
      wr(`SYN_ADDR_DIV_CTL, 8'h01);
      v = 16'(ratio / 2 - 1);
    end else begin
      wr(`SYN_ADDR_DIV_CTL, 8'h00);
      v = 16'(ratio - 1);
    end
    wr(`SYN_ADDR_DIV_LO, v[7:0]);
    wr(`SYN_ADDR_DIV_HI, v[15:8]);
    update();
  endtask
endmodule // syn_host_model

// >>> tb/syn_clk_cfg_test.sv
`include "syn_consts.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module syn_clk_cfg_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_in;
  logic        rst_in;
  logic [15:0] addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        upd_pin;
  logic        fb_pin;
  logic [3:0]  straps;
  logic [6:0]  fb_ratio;
  logic        ref_dbl;
  logic        osc_band;
  logic        cp_on;
  logic [8:0]  cp_ua;
  logic [13:0] phase;
  logic [13:0] p0;
  logic        cmos_div;
  int          errors;
  int          check_count;
  int          g;
  logic [8:0]  ua_tbl [4] = '{9'h0fa, 9'h177, 9'h000, 9'h07d};
  logic [4:0]  n_tbl [3] = '{5'h00, 5'h05, 5'h1f};

  syn_host_model host_u (.clk_in(ref_clk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
  syn_clk_cfg #(.REF_MHZ(50), .PH_W(14)) dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .io_update_pin_in(upd_pin),
    .feedback_input_pin_in(fb_pin), .startup_straps_in(straps), .fb_ratio_out(fb_ratio),
    .ref_dbl_out(ref_dbl), .osc_band_out(osc_band), .cp_on_out(cp_on), .cp_ua_out(cp_ua),
    .phase_out(phase), .cmos_div_out(cmos_div));

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  // divider reference: 8 clock period, asynchronous to the bus traffic
  initial begin
    fb_pin = 1'b0;
    forever begin
      repeat (4) @(negedge ref_clk_in);
      fb_pin = ~fb_pin;
    end
  end
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    errors++;
    final_report();
  end

  task automatic final_report();
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    host_u.rd(a, d, ok);
    if (!ok) begin
      errors++;
      final_report();
    end
    `CHK(d, exp)
  endtask
  task automatic settle();
    repeat (6) @(negedge ref_clk_in);
  endtask
  // cycles between two divided output pulses
  task automatic gap();
    int n;
    n = 0;
    // skip a pulse launched under the old settings
    @(negedge ref_clk_in);
    while (cmos_div !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_in);
      n++;
    end
    g = 0;
    do begin
      @(negedge ref_clk_in);
      g++;
    end while (cmos_div !== 1'b1 && g < 3000);
    if (n == 3000 || g == 3000) begin
      errors++;
      final_report();
    end
  endtask
  task automatic step_chk(input logic [13:0] exp);
    p0 = phase;
    @(negedge ref_clk_in);
    `CHK(14'(phase - p0), exp)
  endtask

  initial begin
    errors = 0;
    check_count = 0;
    upd_pin = 1'b0;
    straps = 4'ha;
    rst_in = 1'b1;
    repeat (10) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (5) @(negedge ref_clk_in);
    rd_chk(16'h01ab, {straps, 4'h0});
    rd_chk(`SYN_ADDR_TUNING_WORD_BYTE0, 8'h00);
    rd_chk(`SYN_ADDR_RSVD, 8'h00);
    rd_chk(16'h0300, 8'h00);
    rd_chk(`SYN_ADDR_UPDATE, 8'h00);
    foreach (n_tbl[i]) begin
      host_u.pll(n_tbl[i], 8'h00);
      settle();
      `CHK(fb_ratio, 7'(2 * (n_tbl[i] + 2)))
      rd_chk(`SYN_ADDR_NDIV, {3'h0, n_tbl[i]});
    end
    for (int c = 0; c < 4; c++) begin
      host_u.wr(`SYN_ADDR_PLL, {4'h0, c[0], c[1], c[1:0]});
      if (c == 3) begin
        @(negedge ref_clk_in);
        upd_pin = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        upd_pin = 1'b0;
      end else host_u.update();
      settle();
      `CHK(cp_ua, ua_tbl[c])
      `CHK(cp_on, 1'(c != 2))
      `CHK(ref_dbl, 1'(c[0]))
      `CHK(osc_band, 1'(c[1]))
    end
    // written band bit is ignored while auto select is on
    host_u.pll(5'h06, 8'h84);
    settle();
    `CHK(osc_band, 1'b0)
    rd_chk(`SYN_ADDR_PLL, 8'h80);
    host_u.pll(5'h08, 8'h80);
    settle();
    `CHK(osc_band, 1'b1)
    rd_chk(`SYN_ADDR_PLL, 8'h84);
    host_u.set_divider(3);
    gap();
    `CHK(g, 24)
    host_u.wr(`SYN_ADDR_DIV_LO, 8'h00);
    host_u.update();
    gap();
    `CHK(g, 8)
    host_u.wr(`SYN_ADDR_DIV_HI, 8'h01);
    host_u.update();
    gap();
    `CHK(g, 2056)
    rd_chk(`SYN_ADDR_DIV_HI, 8'h01);
    host_u.wr(`SYN_ADDR_DIV_HI, 8'h00);
    host_u.wr(`SYN_ADDR_DIV_LO, 8'h02);
    host_u.wr(`SYN_ADDR_DIV_CTL, 8'h01);
    host_u.update();
    gap();
    `CHK(g, 48)
    host_u.wr(`SYN_ADDR_DIV_CTL, 8'hff);
    host_u.update();
    gap();
    `CHK(g, 48)
    rd_chk(`SYN_ADDR_DIV_CTL, 8'h81);
    host_u.wr(`SYN_ADDR_DIV_CTL, 8'h80);
    host_u.update();
    gap();
    `CHK(g, 24)
    // word bit 34 is the lowest phase bit: one step per cycle
    host_u.wr(16'h01ab, 8'h00);
    host_u.wr(16'h01aa, 8'h04);
    host_u.update();
    settle();
    repeat (4) step_chk(14'h0001);
    fork
      begin
        host_u.wr(16'h01aa, 8'h08);
        host_u.update();
      end
      repeat (12) begin
        p0 = phase;
        @(negedge ref_clk_in);
        `CHK(1'(14'(phase - p0) == 14'h1 || 14'(phase - p0) == 14'h2), 1'b1)
      end
    join
    repeat (4) step_chk(14'h0002);
    final_report();
  end
endmodule // syn_clk_cfg_test
